/* File: design/bisr_regs.sv */
// Board id, build info and boot image select registers on AXI4-Lite
//
// Summary of operation
// - Decode three registers at CA0h or C90h base.
// - Stored lamp bit drives user lamp active low.
// - Low seven bits return fixed board code.
// - Second register read-only, top five revision.
// - Temperature grade bit: zero standard, one wide.
// - Special build bit: zero standard, one custom.
// - Lowest bit: zero standard, one pre-release.
// - Boot register top bit reads jumper state.
// - Override bit set makes selection bit decide.
// - Selection bit: zero backup, one primary image.
// - Low five boot bits reserved, no effect.
//
// Design decision made here: register access over AXI4-Lite.
`default_nettype none

module bisr_regs #(
  // Arbitrary neutral value, not a real product code
  parameter logic [6:0] BOARD_TYPE_CODE      = 7'h2a,
  parameter logic [4:0] LOGIC_BUILD_REVISION = 5'h01,
  parameter logic       WIDE_TEMP_GRADE      = 1'b0,
  parameter logic       SPECIAL_BUILD        = 1'b0,
  parameter logic       PRE_RELEASE          = 1'b0
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_b_i,
  input  wire logic [bisr_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output var  logic                          s_axi_awready,
  input  wire logic [bisr_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output var  logic                          s_axi_wready,
  output var  logic [1:0]                    s_axi_bresp,
  output var  logic                          s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [bisr_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output var  logic                          s_axi_arready,
  output var  logic [bisr_pkg::DATA_W-1:0]   s_axi_rdata,
  output var  logic [1:0]                    s_axi_rresp,
  output var  logic                          s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          boot_jumper_state_i,
  input  wire logic                          alt_base_sel_i,
  output var  logic                          user_lamp_ctl_b_o,
  output var  logic                          boot_image_primary_o
);

  // ==========================================================================
  // Strap synchronisation
  // ==========================================================================
  logic jmp_s;
  logic alt_s;

  bisr_sync2 u_sync (
    .ref_clk_i     (ref_clk_i),
    .rst_b_i       (rst_b_i),
    .jumper_pin_i  (boot_jumper_state_i),
    .alt_pin_i     (alt_base_sel_i),
    .jumper_sync_o (jmp_s),
    .alt_sync_o    (alt_s)
  );

  // ==========================================================================
  // State
  // ==========================================================================
  logic                        awready_reg,  awready_next;
  logic                        wready_reg,   wready_next;
  logic                        aw_held_reg,  aw_held_next;
  logic                        w_held_reg,   w_held_next;
  logic [bisr_pkg::ADDR_W-1:0] awaddr_reg,   awaddr_next;
  logic [7:0]                  wdata_reg,    wdata_next;
  logic                        wstrb0_reg,   wstrb0_next;
  logic                        bvalid_reg,   bvalid_next;
  logic [1:0]                  bresp_reg,    bresp_next;
  logic                        arready_reg,  arready_next;
  logic                        rvalid_reg,   rvalid_next;
  logic [bisr_pkg::DATA_W-1:0] rdata_reg,    rdata_next;
  logic [1:0]                  rresp_reg,    rresp_next;
  bisr_pkg::bisr_ctl_t         ctl_reg,      ctl_next;
  logic                        boot_sel_reg, boot_sel_next;

  logic                        wr_fire;
  logic                        rd_fire;
  bisr_pkg::bisr_sel_t         wr_sel;
  bisr_pkg::bisr_sel_t         rd_sel;

  // ==========================================================================
  // Write path
  // ==========================================================================
  // Address and data are caught in either order; the register is updated
  // only once both are held, and no new pair is taken until B is accepted.
  always_comb begin
    aw_held_next = aw_held_reg;
    w_held_next  = w_held_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb0_next  = wstrb0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    ctl_next     = ctl_reg;
    wr_fire      = aw_held_reg && w_held_reg && !bvalid_reg;
    wr_sel       = bisr_pkg::bisr_decode(awaddr_reg, alt_s);
    if (s_axi_awvalid && awready_reg) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata[7:0];
      wstrb0_next = s_axi_wstrb[0];
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      if (wr_sel == bisr_pkg::SEL_NONE) begin
        bresp_next = bisr_pkg::RESP_SLVERR;
      end else begin
        bresp_next = bisr_pkg::RESP_OKAY;
      end
      // Board code, build info, jumper and reserved bits have no storage,
      // so writes to them cannot change anything
      if (wstrb0_reg) begin
        case (wr_sel)
          bisr_pkg::SEL_LAMP: begin
            ctl_next.lamp_off = wdata_reg[bisr_pkg::LAMP_BIT];
          end
          bisr_pkg::SEL_BOOT: begin
            ctl_next.override = wdata_reg[bisr_pkg::OVR_BIT];
            ctl_next.choice   = wdata_reg[bisr_pkg::CHOICE_BIT];
          end
          default: begin
            ctl_next = ctl_reg;
          end
        endcase
      end
    end
    awready_next = !aw_held_next && !bvalid_next;
    wready_next  = !w_held_next && !bvalid_next;
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  always_comb begin
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    rd_fire      = s_axi_arvalid && arready_reg;
    rd_sel       = bisr_pkg::bisr_decode(s_axi_araddr, alt_s);
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rdata_next  = '0;
      rresp_next  = bisr_pkg::RESP_OKAY;
      case (rd_sel)
        bisr_pkg::SEL_LAMP: begin
          rdata_next[bisr_pkg::LAMP_BIT]   = ctl_reg.lamp_off;
          rdata_next[bisr_pkg::TYPE_MSB:0] = BOARD_TYPE_CODE;
        end
        bisr_pkg::SEL_REV: begin
          rdata_next[bisr_pkg::REV_MSB:bisr_pkg::REV_LSB] =
            LOGIC_BUILD_REVISION;
          rdata_next[bisr_pkg::WIDE_TEMP_BIT] = WIDE_TEMP_GRADE;
          rdata_next[bisr_pkg::SPECIAL_BIT]   = SPECIAL_BUILD;
          rdata_next[bisr_pkg::PRE_REL_BIT]   = PRE_RELEASE;
        end
        bisr_pkg::SEL_BOOT: begin
          rdata_next[bisr_pkg::JMP_BIT]    = jmp_s;
          rdata_next[bisr_pkg::OVR_BIT]    = ctl_reg.override;
          rdata_next[bisr_pkg::CHOICE_BIT] = ctl_reg.choice;
        end
        default: begin
          rresp_next = bisr_pkg::RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  // ==========================================================================
  // Boot image select
  // ==========================================================================
  // Registered so the pin is glitch free; it trails the fields by one cycle
  always_comb begin
    if (ctl_reg.override) begin
      boot_sel_next = ctl_reg.choice;
    end else begin
      boot_sel_next = jmp_s;
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      awready_reg  <= 1'b1;
      wready_reg   <= 1'b1;
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= 8'h00;
      wstrb0_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      bresp_reg    <= bisr_pkg::RESP_OKAY;
      arready_reg  <= 1'b1;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= '0;
      rresp_reg    <= bisr_pkg::RESP_OKAY;
      ctl_reg      <= bisr_pkg::CTL_RST;
      boot_sel_reg <= bisr_pkg::JMP_RST;
    end else begin
      awready_reg  <= awready_next;
      wready_reg   <= wready_next;
      aw_held_reg  <= aw_held_next;
      w_held_reg   <= w_held_next;
      awaddr_reg   <= awaddr_next;
      wdata_reg    <= wdata_next;
      wstrb0_reg   <= wstrb0_next;
      bvalid_reg   <= bvalid_next;
      bresp_reg    <= bresp_next;
      arready_reg  <= arready_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      ctl_reg      <= ctl_next;
      boot_sel_reg <= boot_sel_next;
    end
  end

  assign s_axi_awready        = awready_reg;
  assign s_axi_wready         = wready_reg;
  assign s_axi_bvalid         = bvalid_reg;
  assign s_axi_bresp          = bresp_reg;
  assign s_axi_arready        = arready_reg;
  assign s_axi_rvalid         = rvalid_reg;
  assign s_axi_rdata          = rdata_reg;
  assign s_axi_rresp          = rresp_reg;
  assign user_lamp_ctl_b_o    = ctl_reg.lamp_off;
  assign boot_image_primary_o = boot_sel_reg;

  // ==========================================================================
  // Checks
  // ==========================================================================
  a_decode_miss_err: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_fire && rd_sel == bisr_pkg::SEL_NONE
    |=> s_axi_rvalid && s_axi_rresp == bisr_pkg::RESP_SLVERR
        && s_axi_rdata == 32'h0000_0000)
  else $error("Unmapped read not answered with error and zero");

  a_decode_hit_okay: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_fire && wr_sel != bisr_pkg::SEL_NONE
    |=> s_axi_bvalid && s_axi_bresp == bisr_pkg::RESP_OKAY)
  else $error("Mapped write not answered with okay");

  a_lamp_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_fire && wr_sel == bisr_pkg::SEL_LAMP && wstrb0_reg
    |=> user_lamp_ctl_b_o == $past(wdata_reg[bisr_pkg::LAMP_BIT]))
  else $error("Lamp output does not follow written bit");

  a_lamp_readback: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_fire && rd_sel == bisr_pkg::SEL_LAMP
    |=> s_axi_rdata[bisr_pkg::LAMP_BIT] == $past(user_lamp_ctl_b_o))
  else $error("Lamp bit read back differs from lamp output");

  a_type_code_fixed: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_fire && rd_sel == bisr_pkg::SEL_LAMP
    |=> s_axi_rdata[bisr_pkg::TYPE_MSB:0] == BOARD_TYPE_CODE
        && s_axi_rdata[31:8] == 24'h00_0000)
  else $error("Board type code read wrong");

  a_rev_fields: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_fire && rd_sel == bisr_pkg::SEL_REV
    |=> s_axi_rdata == {24'h00_0000, LOGIC_BUILD_REVISION,
                        WIDE_TEMP_GRADE, SPECIAL_BUILD, PRE_RELEASE})
  else $error("Build info read wrong");

  a_rev_no_store: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_fire && wr_sel == bisr_pkg::SEL_REV |=> ctl_reg == $past(ctl_reg))
  else $error("Write to build info changed control state");

  a_boot_jumper_rd: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    rd_fire && rd_sel == bisr_pkg::SEL_BOOT
    |=> s_axi_rdata[bisr_pkg::JMP_BIT] == $past(jmp_s)
        && s_axi_rdata[4:0] == 5'h00)
  else $error("Boot register jumper or reserved bits read wrong");

  a_boot_override: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    ctl_reg.override |=> boot_image_primary_o == $past(ctl_reg.choice))
  else $error("Override set but select ignores choice bit");

  a_boot_jumper_wins: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !ctl_reg.override [*2] |-> boot_image_primary_o == $past(jmp_s))
  else $error("No override but select ignores jumper");

  a_boot_write: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    wr_fire && wr_sel == bisr_pkg::SEL_BOOT && wstrb0_reg
    |=> ctl_reg.override == $past(wdata_reg[bisr_pkg::OVR_BIT])
        && ctl_reg.choice == $past(wdata_reg[bisr_pkg::CHOICE_BIT])
        && ctl_reg.lamp_off == $past(ctl_reg.lamp_off))
  else $error("Boot write stored wrong bits");

  a_resp_held: assert property (
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
  else $error("Read answer dropped before acceptance");

endmodule : bisr_regs

`default_nettype wire

/* File: design/bisr_pkg.sv */
// Constants, types and address decode shared by the board id register bank
`default_nettype none

package bisr_pkg;

  // ==========================================================================
  // Bus geometry and responses
  // ==========================================================================
  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned DATA_W      = 32;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register indices; byte address is four times the index
  // ==========================================================================
  localparam logic [11:0] IDX_LAMP     = 12'hca0;
  localparam logic [11:0] IDX_REV      = 12'hca1;
  localparam logic [11:0] IDX_BOOT     = 12'hca2;
  localparam logic [11:0] IDX_LAMP_ALT = 12'hc90;
  localparam logic [11:0] IDX_REV_ALT  = 12'hc91;
  localparam logic [11:0] IDX_BOOT_ALT = 12'hc92;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int unsigned LAMP_BIT      = 7;
  localparam int unsigned TYPE_MSB      = 6;
  localparam int unsigned REV_MSB       = 7;
  localparam int unsigned REV_LSB       = 3;
  localparam int unsigned WIDE_TEMP_BIT = 2;
  localparam int unsigned SPECIAL_BIT   = 1;
  localparam int unsigned PRE_REL_BIT   = 0;
  localparam int unsigned JMP_BIT       = 7;
  localparam int unsigned OVR_BIT       = 6;
  localparam int unsigned CHOICE_BIT    = 5;

  // ==========================================================================
  // Types and reset values
  // ==========================================================================
  typedef struct packed {
    logic lamp_off;
    logic override;
    logic choice;
  } bisr_ctl_t;

  localparam bisr_ctl_t CTL_RST = '{lamp_off: 1'b1, override: 1'b0,
                                    choice: 1'b1};
  localparam logic      JMP_RST = 1'b1;
  localparam logic      ALT_RST = 1'b0;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_LAMP,
    SEL_REV,
    SEL_BOOT
  } bisr_sel_t;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  function automatic bisr_sel_t bisr_decode(input logic [ADDR_W-1:0] addr,
                                            input logic              alt);
    logic [13:0] idx;
    idx = addr[ADDR_W-1:2];
    if (!alt && idx == {2'b00, IDX_LAMP}) begin
      return SEL_LAMP;
    end else if (!alt && idx == {2'b00, IDX_REV}) begin
      return SEL_REV;
    end else if (!alt && idx == {2'b00, IDX_BOOT}) begin
      return SEL_BOOT;
    end else if (alt && idx == {2'b00, IDX_LAMP_ALT}) begin
      return SEL_LAMP;
    end else if (alt && idx == {2'b00, IDX_REV_ALT}) begin
      return SEL_REV;
    end else if (alt && idx == {2'b00, IDX_BOOT_ALT}) begin
      return SEL_BOOT;
    end else begin
      return SEL_NONE;
    end
  endfunction : bisr_decode

endpackage : bisr_pkg

`default_nettype wire

/* File: design/bisr_sync2.sv */
// Two-flop synchroniser for the board strap pins
`default_nettype none

module bisr_sync2 (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic jumper_pin_i,
  input  wire logic alt_pin_i,
  output var  logic jumper_sync_o,
  output var  logic alt_sync_o
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  logic [1:0] meta_reg;
  logic [1:0] meta_next;
  logic [1:0] sync_reg;
  logic [1:0] sync_next;

  always_comb begin
    meta_next = {alt_pin_i, jumper_pin_i};
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= {bisr_pkg::ALT_RST, bisr_pkg::JMP_RST};
      sync_reg <= {bisr_pkg::ALT_RST, bisr_pkg::JMP_RST};
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign jumper_sync_o = sync_reg[0];
  assign alt_sync_o    = sync_reg[1];

endmodule : bisr_sync2

`default_nettype wire

/* File: tb/bisr_host.sv */
// Host processor model: AXI4-Lite master issuing register accesses
`default_nettype none

module bisr_host (
  input  wire logic        ref_clk_i,
  output var  logic [15:0] awaddr_o,
  output var  logic        awvalid_o,
  input  wire logic        awready_i,
  output var  logic [31:0] wdata_o,
  output var  logic [3:0]  wstrb_o,
  output var  logic        wvalid_o,
  input  wire logic        wready_i,
  input  wire logic [1:0]  bresp_i,
  input  wire logic        bvalid_i,
  output var  logic        bready_o,
  output var  logic [15:0] araddr_o,
  output var  logic        arvalid_o,
  input  wire logic        arready_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic [1:0]  rresp_i,
  input  wire logic        rvalid_i,
  output var  logic        rready_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
    {araddr_o, arvalid_o, rready_o} = '0;
  end

  // ==========================================================================
  // Bus cycles; released payloads are inverted so stale values never match
  // ==========================================================================
  task automatic write_reg(input logic [15:0] addr, input logic [7:0] data,
                           input logic [3:0] strb, output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge ref_clk_i);
    awaddr_o  <= addr;
    awvalid_o <= 1'b1;
    wdata_o   <= {24'h000000, data};
    wstrb_o   <= strb;
    wvalid_o  <= 1'b1;
    bready_o  <= 1'b1;
    while (!done) begin
      @(posedge ref_clk_i);
      if (awvalid_o && awready_i) begin
        awvalid_o <= 1'b0;
        awaddr_o  <= ~addr;
      end
      if (wvalid_o && wready_i) begin
        wvalid_o <= 1'b0;
        wdata_o  <= ~wdata_o;
      end
      if (bready_o && bvalid_i) begin
        resp = bresp_i;
        bready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : write_reg

  task automatic read_reg(input logic [15:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    logic done;
    done = 1'b0;
    @(posedge ref_clk_i);
    araddr_o  <= addr;
    arvalid_o <= 1'b1;
    rready_o  <= 1'b1;
    while (!done) begin
      @(posedge ref_clk_i);
      if (arvalid_o && arready_i) begin
        arvalid_o <= 1'b0;
        araddr_o  <= ~addr;
      end
      if (rready_o && rvalid_i) begin
        data = rdata_i;
        resp = rresp_i;
        rready_o <= 1'b0;
        done = 1'b1;
      end
    end
  endtask : read_reg

endmodule : bisr_host

`default_nettype wire

/* File: tb/bisr_regs_bench.sv */
// Self-checking bench for the board id and boot select register bank
`default_nettype none

module bisr_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // Constants off their defaults, except SPEC_C, so swapped or stuck fields show up
  localparam logic [6:0] TYPE_C = 7'h55;
  localparam logic [4:0] REV_C  = 5'h13;
  localparam logic       WIDE_C = 1'b1;
  localparam logic       SPEC_C = 1'b0;
  localparam logic       PRE_C  = 1'b1;

  logic        ref_clk, rst_b, jmp_pin, alt_pin, lamp_b, boot_pri;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic        lamp_off, ovr, ch, hit;
  logic [11:0] base;
  logic [7:0]  d;
  logic [3:0]  s;
  logic [1:0]  r;
  int          seed, mismatches, n_checks, cycles, k;

  bisr_regs #(.BOARD_TYPE_CODE(TYPE_C), .LOGIC_BUILD_REVISION(REV_C),
              .WIDE_TEMP_GRADE(WIDE_C), .SPECIAL_BUILD(SPEC_C),
              .PRE_RELEASE(PRE_C)) bisr_regs_i (
    .ref_clk_i(ref_clk), .rst_b_i(rst_b),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .boot_jumper_state_i(jmp_pin),
    .alt_base_sel_i(alt_pin), .user_lamp_ctl_b_o(lamp_b),
    .boot_image_primary_o(boot_pri));

  bisr_host bisr_host_i (
    .ref_clk_i(ref_clk), .awaddr_o(awaddr), .awvalid_o(awvalid),
    .awready_i(awready), .wdata_o(wdata), .wstrb_o(wstrb),
    .wvalid_o(wvalid), .wready_i(wready), .bresp_i(bresp),
    .bvalid_i(bvalid), .bready_o(bready), .araddr_o(araddr),
    .arvalid_o(arvalid), .arready_i(arready), .rdata_i(rdata),
    .rresp_i(rresp), .rvalid_i(rvalid), .rready_o(rready));

  // ==========================================================================
  // Expectations and comparisons
  // ==========================================================================
  function automatic logic [31:0] exp_word(input int sel);
    case (sel)
      0:       return {24'h000000, lamp_off, TYPE_C};
      1:       return {24'h000000, REV_C, WIDE_C, SPEC_C, PRE_C};
      default: return {24'h000000, jmp_pin, ovr, ch, 5'h00};
    endcase
  endfunction : exp_word

  function automatic logic [15:0] addr_of(input logic [11:0] b, input int o);
    return {2'b00, b + 12'(o), 2'b00};
  endfunction : addr_of

  task automatic chk_word(input string what, input logic [31:0] exp,
                          input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk_bit

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  // Reads all three registers at the live base and checks both pin outputs
  task automatic check_all();
    logic [31:0] v;
    logic [1:0]  rr;
    base = alt_pin ? bisr_pkg::IDX_LAMP_ALT : bisr_pkg::IDX_LAMP;
    for (int i = 0; i < 3; i++) begin
      bisr_host_i.read_reg(addr_of(base, i), v, rr);
      chk_word("read data", exp_word(i), v);
      chk_word("read resp", bisr_pkg::RESP_OKAY, {30'h0, rr});
    end
    #1;
    chk_bit("lamp pin", lamp_off, lamp_b);
    chk_bit("boot select", ovr ? ch : jmp_pin, boot_pri);
  endtask : check_all

  // ==========================================================================
  // Clock, timeout and main sequence
  // ==========================================================================
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 10000) begin
      mismatches++;
      final_report();
    end
  end

  initial begin
    seed       = 38467;
    mismatches = 0;
    n_checks   = 0;
    cycles     = 0;
    {rst_b, jmp_pin, alt_pin, lamp_off, ovr, ch} = 6'b010101;
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    check_all();
    bisr_host_i.read_reg(16'h0004, rd_v, r);
    chk_word("unmapped read", 32'h00000002, {30'h0, r});
    chk_word("unmapped data", 32'h00000000, rd_v);
    for (int n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      jmp_pin <= 1'($random(seed));
      alt_pin <= 1'($random(seed));
      repeat (4) @(posedge ref_clk);
      k = {$random(seed)} % 3;
      hit = ($random(seed) % 4) != 0;
      base = (alt_pin ^ !hit) ? bisr_pkg::IDX_LAMP_ALT : bisr_pkg::IDX_LAMP;
      d = 8'($random(seed));
      s = 4'($random(seed));
      bisr_host_i.write_reg(addr_of(base, k), d, s, r);
      chk_word("write resp", hit ? 32'h0 : 32'h2, {30'h0, r});
      if (hit && s[0] && k == 0) lamp_off = d[7];
      if (hit && s[0] && k == 2) {ovr, ch} = d[6:5];
      repeat (2) @(posedge ref_clk);
      check_all();
    end
    // Second reset in mid-run returns every writable field to its default
    @(posedge ref_clk);
    jmp_pin <= 1'b1;
    alt_pin <= 1'b0;
    rst_b   <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    {lamp_off, ovr, ch} = 3'b101;
    repeat (4) @(posedge ref_clk);
    check_all();
    final_report();
  end

endmodule : bisr_regs_bench

`default_nettype wire
